// ---- src/olc_pkg.sv ----
// package for the octal low-side output control block
package olc_pkg;
   // timing
   localparam int CLK_HZ = 100000000;
   localparam int RETRY_US = 1200;
   localparam int RETRY_CYCLES = RETRY_US * (CLK_HZ / 1000000);
   localparam int RETRY_W = 18;
   // geometry
   localparam int NCH = 8;
   localparam int GRP = 4;
   localparam int NGRP = 2;
   // register map (byte addresses)
   localparam logic [11:0] ADDR_COMMAND = 12'h000;
   localparam logic [11:0] ADDR_CONTROL = 12'h004;
   localparam logic [11:0] ADDR_STATE = 12'h008;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h00C;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
   // control register fields and reset values
   localparam int CTRL_RESET_BIT = 0;
   localparam int CTRL_ENABLE_N_BIT = 1;
   localparam logic [1:0] CTRL_RESET_VAL = 2'h3;
   localparam logic [7:0] CMD_RESET_VAL = 8'h00;
   localparam logic [3:0] MASK_RESET_VAL = 4'h0;
   // irq status layout: [1:0] overcurrent per group, [3:2] thermal per group
   localparam int IRQ_OC_LSB = 0;
   localparam int IRQ_TH_LSB = 2;
   // per-channel protection state
   typedef enum logic [1:0] {
      OLC_CH_OFF = 2'b00,
      OLC_CH_ON = 2'b01,
      OLC_CH_TRIP = 2'b10
   } olc_ch_state_t;
   // field-side sense inputs
   typedef struct packed {
      logic [7:0] overcurrent;
      logic [1:0] overtemp;
      logic field_supply_ok;
   } olc_sense_t;
endpackage

// ---- src/olc_output_control.sv ----
// octal low-side output control: apb registers, channel drive and fault handling
`timescale 1ns/10ps
// port overview:
// apb slave side: psel, penable, pwrite, paddr, pwdata in; prdata, pready, pslverr out
// sense: field-side overcurrent per channel, overtemperature per group, supply present
// switch_on: one bit per channel, high while its low-side switch pulls the load low
// group_a_fault_n: low while channels 0-3 have a trip, or while their die is hot and the module is active
// group_b_fault_n: low while channels 4-7 have a trip, or while their die is hot and the module is active
// irq: level, high while any unmasked sticky event bit is set
// all inputs are taken as synchronous to clk; the host side must
// synchronise the fault lines itself if it runs on another clock
// reset is synchronous and active high; it parks every switch off
// and loads the control register with both host lines high
// the retry wait is a parameter so a bench can shorten it
module olc_output_control #(
   parameter int RETRY_CYCLES = olc_pkg::RETRY_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire olc_pkg::olc_sense_t sense,
   output logic [7:0] switch_on,
   output logic group_a_fault_n,
   output logic group_b_fault_n,
   output logic irq
);
   // register map in short:
   // command: one on/off bit per channel, only acted on while active
   // control: bit 0 is the driver reset level, bit 1 the active-low enable
   // state: read-only view of switch_on and the two internal group faults
   // irq status: sticky, write one to clear; overcurrent per group below,
   // overtemperature per group above
   // irq mask: same layout as irq status, all masked after reset
   // unmapped offsets read zero and swallow writes without an error,
   // so a host that probes the map never sees pslverr
   // the control register stands in for the two host pins; its reset
   // value of both lines high is the safe floating-pin level
   // register state
   logic [7:0] cmd, next_cmd; // per-channel on/off commands
   logic [1:0] ctrl, next_ctrl; // driver_reset_pin and drive_enable_n
   logic [3:0] irq_status, next_irq_status; // sticky events
   logic [3:0] irq_mask, next_irq_mask; // interrupt enables
   logic [31:0] next_prdata;
   // channel state
   olc_pkg::olc_ch_state_t ch_state [olc_pkg::NCH];
   olc_pkg::olc_ch_state_t next_ch_state [olc_pkg::NCH];
   logic [olc_pkg::RETRY_W-1:0] ch_timer [olc_pkg::NCH];
   logic [olc_pkg::RETRY_W-1:0] next_ch_timer [olc_pkg::NCH];
   logic [7:0] next_switch_on;
   logic [1:0] grp_fault, next_grp_fault; // active-high internal fault per group
   logic driver_reset_pin; // driver reset level
   logic drive_enable_n; // active-low enable level
   logic active; // module allowed to switch
   logic wr_en; // apb write strobe
   logic rd_en; // apb read strobe
   logic [7:0] trip_evt; // new overcurrent cut-off this cycle
   localparam logic [olc_pkg::RETRY_W-1:0] RETRY_LAST =
      olc_pkg::RETRY_W'(RETRY_CYCLES - 1);

   // address decode, shared by read and write paths
   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   // group index of a channel
   function automatic int grp_of(input int ch);
      grp_of = ch / olc_pkg::GRP;
   endfunction

   // bus timing: a transfer always takes two cycles
   // setup cycle: read data is captured from the live registers
   // access cycle: pready is already high, so a write lands here
   // capturing reads in setup costs a flop stage but keeps prdata
   // registered, which avoids a long path from the decode to the pins
   // limitation: a read of state returns the value of the setup cycle,
   // one cycle older than the access edge
   // zero-wait apb slave: answer in the first access cycle
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   assign driver_reset_pin = ctrl[olc_pkg::CTRL_RESET_BIT];
   assign drive_enable_n = ctrl[olc_pkg::CTRL_ENABLE_N_BIT];
   // gate switching on both control lines
   assign active = !driver_reset_pin && !drive_enable_n;

   // next values of the software-visible registers
   // order inside this process matters: the write-one-to-clear comes
   // first and the event sets come after, so an event that falls in the
   // same cycle as a clear is never lost
   // overtemperature sets its sticky bit even while the module is idle,
   // so software can see a hot die before it enables the drivers
   // read data is only recomputed on a read setup and otherwise held,
   // which keeps prdata stable through the access cycle
   // register file next values
   always_comb begin
      next_cmd = cmd;
      next_ctrl = ctrl;
      next_irq_mask = irq_mask;
      next_irq_status = irq_status;
      next_prdata = prdata;
      // write-one-to-clear first, so events below win
      if (wr_en) begin
         if (hit(paddr, olc_pkg::ADDR_COMMAND)) begin
            next_cmd = pwdata[7:0];
         end
         if (hit(paddr, olc_pkg::ADDR_CONTROL)) begin
            next_ctrl = pwdata[1:0];
         end
         if (hit(paddr, olc_pkg::ADDR_IRQ_MASK)) begin
            next_irq_mask = pwdata[3:0];
         end
         if (hit(paddr, olc_pkg::ADDR_IRQ_STATUS)) begin
            next_irq_status = irq_status & ~pwdata[3:0];
         end
      end
      // sticky events: overcurrent trips and overtemperature per group
      for (int g = 0; g < olc_pkg::NGRP; g++) begin
         if (|trip_evt[g*olc_pkg::GRP +: olc_pkg::GRP]) begin
            next_irq_status[olc_pkg::IRQ_OC_LSB + g] = 1'b1;
         end
         if (sense.overtemp[g]) begin
            next_irq_status[olc_pkg::IRQ_TH_LSB + g] = 1'b1;
         end
      end
      // read data sampled in setup, held through access
      if (rd_en) begin
         next_prdata = 32'h0000_0000;
         if (hit(paddr, olc_pkg::ADDR_COMMAND)) begin
            next_prdata[7:0] = cmd;
         end else if (hit(paddr, olc_pkg::ADDR_CONTROL)) begin
            next_prdata[1:0] = ctrl;
         end else if (hit(paddr, olc_pkg::ADDR_STATE)) begin
            next_prdata[7:0] = switch_on;
            next_prdata[9:8] = grp_fault;
         end else if (hit(paddr, olc_pkg::ADDR_IRQ_STATUS)) begin
            next_prdata[3:0] = irq_status;
         end else if (hit(paddr, olc_pkg::ADDR_IRQ_MASK)) begin
            next_prdata[3:0] = irq_mask;
         end
      end
   end

   // register file flops
   always_ff @(posedge clk) begin
      if (reset) begin
         cmd <= olc_pkg::CMD_RESET_VAL;
         ctrl <= olc_pkg::CTRL_RESET_VAL;
         irq_mask <= olc_pkg::MASK_RESET_VAL;
         irq_status <= 4'h0;
         prdata <= 32'h0000_0000;
      end else begin
         cmd <= next_cmd;
         ctrl <= next_ctrl;
         irq_mask <= next_irq_mask;
         irq_status <= next_irq_status;
         prdata <= next_prdata;
      end
   end

   // level interrupt from unmasked sticky bits
   assign irq = |(irq_status & irq_mask);

   // each channel runs its own small machine:
   // off: switch open, waits for its command bit to go high
   // on: switch closed; an overcurrent trips it at once, a low command
   // opens it again
   // trip: switch open and the group fault held; a timer counts the
   // retry wait, after which the channel follows its command again
   // a persisting short therefore re-trips one cycle after each retry,
   // which keeps the fault line low apart from that single cycle
   // leaving the active state or losing the field supply drops every
   // channel to off and clears its timer, whatever the timer shows
   // overtemperature does not change the machine; it only masks the
   // switch, so the group resumes by itself once the die has cooled
   // per-channel protection machines
   generate
      for (genvar c = 0; c < olc_pkg::NCH; c++) begin : g_ch
         always_comb begin
            next_ch_state[c] = ch_state[c];
            next_ch_timer[c] = ch_timer[c];
            trip_evt[c] = 1'b0;
            next_switch_on[c] = 1'b0;
            // reset or supply loss clears fault and timer
            if (!active || !sense.field_supply_ok) begin
               next_ch_state[c] = olc_pkg::OLC_CH_OFF;
               next_ch_timer[c] = '0;
            end else begin
               case (ch_state[c])
                  olc_pkg::OLC_CH_OFF: begin
                     if (cmd[c]) begin
                        next_ch_state[c] = olc_pkg::OLC_CH_ON;
                     end
                  end
                  olc_pkg::OLC_CH_ON: begin
                     if (sense.overcurrent[c]) begin
                        next_ch_state[c] = olc_pkg::OLC_CH_TRIP;
                        next_ch_timer[c] = '0;
                        trip_evt[c] = 1'b1;
                     end else if (!cmd[c]) begin
                        next_ch_state[c] = olc_pkg::OLC_CH_OFF;
                     end
                  end
                  olc_pkg::OLC_CH_TRIP: begin
                     if (ch_timer[c] == RETRY_LAST) begin
                        next_ch_timer[c] = '0;
                        next_ch_state[c] = cmd[c] ? olc_pkg::OLC_CH_ON : olc_pkg::OLC_CH_OFF;
                     end else begin
                        next_ch_timer[c] = ch_timer[c] + 1'b1;
                     end
                  end
                  default: begin
                     next_ch_state[c] = olc_pkg::OLC_CH_OFF;
                  end
               endcase
            end
            if (next_ch_state[c] == olc_pkg::OLC_CH_ON && !sense.overtemp[grp_of(c)]) begin
               next_switch_on[c] = 1'b1;
            end
         end

         // channel flops
         always_ff @(posedge clk) begin
            if (reset) begin
               ch_state[c] <= olc_pkg::OLC_CH_OFF;
               ch_timer[c] <= '0;
            end else begin
               ch_state[c] <= next_ch_state[c];
               ch_timer[c] <= next_ch_timer[c];
            end
         end
      end
   endgenerate

   // group fault is computed from the next channel states, so the fault
   // flop and the switch flop change on the same edge and the host never
   // sees an open switch without its fault or the other way round
   // overtemperature only raises the fault while the module is active;
   // an idle module has nothing switched that could be harmed
   // group fault: any tripped channel or overtemperature
   always_comb begin
      for (int g = 0; g < olc_pkg::NGRP; g++) begin
         next_grp_fault[g] = sense.overtemp[g] && active;
         for (int k = 0; k < olc_pkg::GRP; k++) begin
            // fault line falls with the cut-off
            if (next_ch_state[g*olc_pkg::GRP + k] == olc_pkg::OLC_CH_TRIP) begin
               next_grp_fault[g] = 1'b1;
            end
         end
      end
   end

   // switch and fault outputs come straight from flops, so no glitch
   // from the decode logic can reach a power switch or a fault pin
   // output flops; outputs off during reset
   always_ff @(posedge clk) begin
      if (reset) begin
         switch_on <= 8'h00;
         grp_fault <= 2'h0;
      end else begin
         switch_on <= next_switch_on;
         grp_fault <= next_grp_fault;
      end
   end

   // the internal faults are active high for easy or-ing; the pins are
   // inverted here so that an idle or reset module shows both lines high
   // one active-low fault per group
   assign group_a_fault_n = !grp_fault[0];
   assign group_b_fault_n = !grp_fault[1];
endmodule

// ---- verif/olc_assertions.sv ----
// port checker for the output control block
`timescale 1ns/10ps
module olc_checker #(
   parameter int RETRY_CYCLES = 20
) (
   input wire logic clk,
   input wire logic reset,
   input wire olc_pkg::olc_sense_t sense,
   input wire logic [7:0] switch_on,
   input wire logic group_a_fault_n,
   input wire logic group_b_fault_n
);
   // slack of a few cycles around the retry wait
   localparam int RETRY_MAX = RETRY_CYCLES + 4;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_reset_safe_state: assert property ($fell(reset) |-> switch_on == 8'h00
      && group_a_fault_n && group_b_fault_n) else $error("unsafe state after reset");
   a_trip_fault_a: assert property (|(sense.overcurrent[3:0] & switch_on[3:0])
      && sense.field_supply_ok |=> !group_a_fault_n) else $error("group a trip missed");
   a_trip_fault_b: assert property (|(sense.overcurrent[7:4] & switch_on[7:4])
      && sense.field_supply_ok |=> !group_b_fault_n) else $error("group b trip missed");
   a_trip_cuts_off: assert property (|(sense.overcurrent & switch_on)
      |=> (switch_on & $past(sense.overcurrent & switch_on)) == 8'h00)
      else $error("tripped channel stayed on");
   a_trip_hold_a: assert property ($fell(group_a_fault_n) |=> !group_a_fault_n [*8])
      else $error("fault released before retry");
   a_retry_bound_a: assert property ($fell(group_a_fault_n) |-> ##[1:RETRY_MAX]
      (group_a_fault_n || switch_on[3:0] != 4'h0)) else $error("no retry in time");
   a_hot_group_off: assert property (sense.overtemp[1] |=> switch_on[7:4] == 4'h0)
      else $error("hot group still on");
   a_hot_fault_b: assert property (sense.overtemp[1] && switch_on[7:4] != 4'h0
      |=> !group_b_fault_n) else $error("hot group fault missed");
   a_supply_clears: assert property (!sense.field_supply_ok |=> switch_on == 8'h00
      && group_a_fault_n && group_b_fault_n) else $error("supply loss kept state");
endmodule

// ---- verif/olc_field_model.sv ----
// field side: loads that may short and driver dies that may overheat
`timescale 1ns/10ps
module olc_field_model (
   input wire logic [7:0] switch_on,
   input wire logic [7:0] short_mask,
   input wire logic [1:0] hot,
   input wire logic supply_ok,
   output olc_pkg::olc_sense_t sense
);
   // overcurrent only flows through a closed switch
   assign sense.overcurrent = switch_on & short_mask;
   // die heat held as long as commanded
   assign sense.overtemp = hot;
   assign sense.field_supply_ok = supply_ok;
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the output control block
`timescale 1ns/10ps
module testbench;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, irq, supply_ok;
   logic group_a_fault_n, group_b_fault_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_q, seed;
   logic [7:0] switch_on, short_mask, cmd;
   logic [1:0] hot;
   olc_pkg::olc_sense_t sense;
   int failures, checked;
   logic [1:0] flt_s1, flt_s2; // host-side copies of the fault lines
   // host two-stage synchroniser on fault lines
   always @(posedge clk) begin
      flt_s1 <= {group_b_fault_n, group_a_fault_n};
      flt_s2 <= flt_s1;
   end
   olc_field_model fld (.switch_on(switch_on), .short_mask(short_mask), .hot(hot),
      .supply_ok(supply_ok), .sense(sense));
   // short retry wait keeps the run brief
   olc_output_control #(.RETRY_CYCLES(20)) dut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sense(sense), .switch_on(switch_on),
      .group_a_fault_n(group_a_fault_n), .group_b_fault_n(group_b_fault_n), .irq(irq));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // expected state word: faults above switches
   function automatic logic [31:0] st(logic [7:0] on, logic [1:0] flt);
      return {22'h0, flt, on};
   endfunction
   task print_verdict;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer, then one idle edge so register effects land
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd_q = prdata;
      psel <= 0;
      penable <= 0;
      if (n >= 50) begin
         failures++;
         print_verdict();
      end else @(posedge clk);
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, short_mask, hot} = '0;
      {reset, supply_ok, seed, failures, checked} = {2'b11, 32'hA1EC5108, 64'h0};
      repeat (5) @(posedge clk);
      reset <= 0;
      @(posedge clk);
      apb(0, olc_pkg::ADDR_CONTROL, 0); check(rd_q, 32'h3);
      apb(0, olc_pkg::ADDR_IRQ_MASK, 0); check(rd_q, 32'h0);
      apb(1, olc_pkg::ADDR_COMMAND, 32'hFF);
      apb(1, olc_pkg::ADDR_CONTROL, 32'h3);
      apb(0, olc_pkg::ADDR_STATE, 0); check(rd_q, st(8'h00, 2'b00));
      // commands low, release reset, then enable
      apb(1, olc_pkg::ADDR_COMMAND, 0);
      apb(1, olc_pkg::ADDR_CONTROL, 32'h2);
      apb(1, olc_pkg::ADDR_CONTROL, 32'h0);
      $display("test start-up done");
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         cmd = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[7:0];
         apb(1, olc_pkg::ADDR_COMMAND, {24'h0, cmd});
         apb(0, olc_pkg::ADDR_STATE, 0); check(rd_q, st(cmd, 2'b00));
      end
      // unmapped place reads zero and ignores writes
      apb(1, 12'h0FC, 32'hFFFFFFFF);
      apb(0, 12'h0FC, 0); check(rd_q, 32'h0);
      check(pslverr, 0);
      $display("test switching done");
      short_mask <= 8'h01;
      apb(1, olc_pkg::ADDR_IRQ_MASK, 32'hF);
      apb(1, olc_pkg::ADDR_COMMAND, 32'h11);
      repeat (3) @(posedge clk);
      apb(0, olc_pkg::ADDR_STATE, 0); check(rd_q, st(8'h10, 2'b01));
      #1 check({group_b_fault_n, group_a_fault_n, irq}, 3'b101);
      repeat (30) @(posedge clk);
      #1 check(group_a_fault_n, 0);
      check(flt_s2, 2'b10);
      short_mask <= 8'h00;
      repeat (30) @(posedge clk);
      apb(0, olc_pkg::ADDR_STATE, 0); check(rd_q, st(8'h11, 2'b00));
      apb(0, olc_pkg::ADDR_IRQ_STATUS, 0); check(rd_q, 32'h1);
      apb(1, olc_pkg::ADDR_IRQ_STATUS, 32'h1);
      #1 check(irq, 0);
      short_mask <= 8'h80;
      apb(1, olc_pkg::ADDR_COMMAND, 32'h80);
      repeat (3) @(posedge clk);
      #1 check(group_b_fault_n, 0);
      apb(1, olc_pkg::ADDR_CONTROL, 32'h1);
      #1 check(group_b_fault_n, 1);
      short_mask <= 8'h00;
      apb(1, olc_pkg::ADDR_CONTROL, 0);
      apb(1, olc_pkg::ADDR_IRQ_STATUS, 32'hF);
      $display("test overcurrent done");
      apb(1, olc_pkg::ADDR_IRQ_MASK, 0);
      apb(1, olc_pkg::ADDR_COMMAND, 32'hFF);
      hot <= 2'b10;
      repeat (3) @(posedge clk);
      apb(0, olc_pkg::ADDR_STATE, 0); check(rd_q, st(8'h0F, 2'b10));
      #1 check(irq, 0);
      apb(1, olc_pkg::ADDR_IRQ_MASK, 32'hF);
      #1 check(irq, 1);
      hot <= 2'b00;
      repeat (3) @(posedge clk);
      apb(0, olc_pkg::ADDR_STATE, 0); check(rd_q, st(8'hFF, 2'b00));
      apb(1, olc_pkg::ADDR_IRQ_STATUS, 32'h8);
      #1 check(irq, 0);
      supply_ok <= 0;
      repeat (2) @(posedge clk);
      apb(0, olc_pkg::ADDR_STATE, 0); check(rd_q, st(8'h00, 2'b00));
      $display("test heat and supply done");
      print_verdict();
   end
endmodule
bind olc_output_control olc_checker #(.RETRY_CYCLES(RETRY_CYCLES)) chk (.clk(clk),
   .reset(reset), .sense(sense), .switch_on(switch_on),
   .group_a_fault_n(group_a_fault_n), .group_b_fault_n(group_b_fault_n));
